//--- fcbu_branch_unit.sv
// Flag-tested conditional relative branch unit with its APB register slave.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE_01 - Taken branch loads counter plus offset plus one.
// RULE_02 - Half-carry-set branch taken only when flag one.
// RULE_03 - Half-carry-clear branch taken only when flag zero.
// RULE_04 - Copy-bit-set branch taken only when flag one.
// RULE_05 - Copy-bit-clear branch taken only when flag zero.
// RULE_06 - Overflow-set branch taken only when flag one.
// RULE_07 - Overflow-clear branch taken only when flag zero.
// RULE_08 - Interrupts-enabled branch taken when enable flag one.
// RULE_09 - Interrupts-disabled branch taken when enable flag zero.
// RULE_10 - No branch ever modifies any status flag.
// RULE_11 - Every branch completes in one or two cycles.
// RULE_12 - Signed-less branch taken when negative xor overflow.
// RULE_13 - False takes one cycle, taken two with flush.
// RULE_14 - Offset is signed, sign-extended before the addition.
module fcbu_branch_unit
  import fcbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  input wire logic [WORD_W-1:0] issue_word,
  input wire logic [7:0] status_flags,
  output logic [PC_W-1:0] program_counter,
  output logic pc_load,
  output logic flush_fetch,
  output logic branch_done,
  output logic branch_taken
);

  // ==========================================================================
  // Address decode helpers
  // ==========================================================================

  // Tells whether a byte address names one of the mapped registers.
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_PC) ||
                 (a == REG_INSTR) || (a == REG_FLAGS) || (a == REG_TAKEN_COUNT);
  endfunction : addr_known

  // ==========================================================================
  // Declarations
  // ==========================================================================
  fcbu_state_t state;
  fcbu_decode_t core_dec;
  fcbu_decode_t sw_dec;
  fcbu_decode_t sel_dec;
  logic ctrl_enable;
  logic sw_pending;
  logic [WORD_W-1:0] sw_word;
  logic refused;
  logic last_taken;
  logic [1:0] last_cycles;
  logic [PC_W-1:0] cur_offset;
  logic [7:0] flag_seen;
  logic [15:0] taken_count;
  logic idle;
  logic core_take;
  logic sw_take;
  logic launch;
  logic apb_setup;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_status;
  logic wr_pc;
  logic wr_instr;
  logic pc_refused;
  logic instr_refused;
  logic sw_dropped;
  logic [31:0] next_prdata;

  // ==========================================================================
  // Condition decoders for the core word and the software word
  // ==========================================================================
  fcbu_cond_eval u_core_eval (
    .word(issue_word),
    .flags(status_flags),
    .dec(core_dec)
  );

  fcbu_cond_eval u_sw_eval (
    .word(sw_word),
    .flags(status_flags),
    .dec(sw_dec)
  );

  // ==========================================================================
  // Issue selection
  // ==========================================================================

  // The core port has priority; a software word waits while the core issues a branch word.
  assign idle = (state == FCBU_IDLE);
  assign core_take = idle & ctrl_enable & issue_valid & core_dec.is_branch;
  assign sw_take = idle & ctrl_enable & ~core_take & sw_pending;
  assign launch = core_take | (sw_take & sw_dec.is_branch);
  assign sw_dropped = sw_take & ~sw_dec.is_branch;
  assign sel_dec = core_take ? core_dec : sw_dec;

  // ==========================================================================
  // APB strobes
  // ==========================================================================

  // Writes take effect only at the edge that completes the access phase.
  assign apb_setup = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite;
  assign wr_ctrl = wr_fire & (paddr == REG_CTRL);
  assign wr_status = wr_fire & (paddr == REG_STATUS);
  assign wr_pc = wr_fire & (paddr == REG_PC);
  assign wr_instr = wr_fire & (paddr == REG_INSTR);

  // A counter write while a branch is running or starting would be lost.
  assign pc_refused = wr_pc & (~idle | launch);
  assign instr_refused = wr_instr & sw_pending & ~sw_take;

  // ==========================================================================
  // Sequencer
  // ==========================================================================

  // A true condition costs a second cycle; a false one ends in the first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FCBU_IDLE;
    end else begin
      case (state)
        FCBU_IDLE: begin
          if (launch && sel_dec.cond_true) begin
            state <= FCBU_BRANCH; // see RULE_13
          end
        end
        FCBU_BRANCH: begin
          state <= FCBU_IDLE; // see RULE_11
        end
        default: begin
          state <= FCBU_IDLE;
        end
      endcase
    end
  end

  // Holds the extended displacement for the second cycle of a taken branch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_offset <= PC_RESET;
    end else if (launch) begin
      cur_offset <= sel_dec.offset; // see RULE_14
    end
  end

  // ==========================================================================
  // Program counter
  // ==========================================================================

  // Branch updates win over a software load of the counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= PC_RESET;
    end else if (state == FCBU_BRANCH) begin
      program_counter <= pc_step(program_counter, cur_offset); // see RULE_01 see RULE_12
    end else if (launch && !sel_dec.cond_true) begin
      program_counter <= pc_step(program_counter, PC_RESET); // see RULE_13
    end else if (wr_pc && !pc_refused) begin
      program_counter <= pwdata[PC_W-1:0];
    end
  end

  // Fetch-side pulses: flush the prefetched word, load, completion and outcome.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load <= 1'b0;
      flush_fetch <= 1'b0;
      branch_done <= 1'b0;
      branch_taken <= 1'b0;
    end else begin
      pc_load <= (state == FCBU_BRANCH) | (launch & ~sel_dec.cond_true);
      flush_fetch <= launch & sel_dec.cond_true; // see RULE_13
      branch_done <= (state == FCBU_BRANCH) | (launch & ~sel_dec.cond_true); // see RULE_11
      branch_taken <= (state == FCBU_BRANCH);
    end
  end

  // ==========================================================================
  // Observation state
  // ==========================================================================

  // Records the outcome and cycle count of the latest branch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_taken <= 1'b0;
      last_cycles <= 2'h0;
    end else if (launch) begin
      last_taken <= sel_dec.cond_true;
      last_cycles <= sel_dec.cond_true ? CYCLES_TAKEN : CYCLES_NOT_TAKEN;
    end
  end

  // Flags are only sampled for read-back; this unit drives no flag at all.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_seen <= 8'h00;
    end else if (launch) begin
      flag_seen <= status_flags; // see RULE_10
    end
  end

  // Counts taken branches, wrapping at the top.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_count <= 16'h0000;
    end else if (state == FCBU_BRANCH) begin
      taken_count <= taken_count + 16'h0001;
    end
  end

  // ==========================================================================
  // Software-visible control
  // ==========================================================================

  // Enable gates both issue sources.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_enable <= CTRL_ENABLE_RESET;
    end else if (wr_ctrl) begin
      ctrl_enable <= pwdata[CTRL_ENABLE_BIT];
    end
  end

  // One software word may wait; it is consumed when the unit takes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_pending <= 1'b0;
      sw_word <= INSTR_RESET;
    end else begin
      if (sw_take) begin
        sw_pending <= 1'b0;
      end
      if (wr_instr && !instr_refused) begin
        sw_pending <= 1'b1;
        sw_word <= pwdata[WORD_W-1:0];
      end
    end
  end

  // Sticky refusal flag; a new refusal beats a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused <= 1'b0;
    end else if (pc_refused || instr_refused || sw_dropped) begin
      refused <= 1'b1;
    end else if (wr_status && pwdata[STAT_REFUSED_BIT]) begin
      refused <= 1'b0;
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================

  // Read data for the addressed register, sampled in the setup cycle.
  always_comb begin
    next_prdata = 32'h00000000;
    case (paddr)
      REG_CTRL: begin
        next_prdata[CTRL_ENABLE_BIT] = ctrl_enable;
      end
      REG_STATUS: begin
        next_prdata[STAT_BUSY_BIT] = (state == FCBU_BRANCH);
        next_prdata[STAT_TAKEN_BIT] = last_taken;
        next_prdata[STAT_PENDING_BIT] = sw_pending;
        next_prdata[STAT_REFUSED_BIT] = refused;
        next_prdata[STAT_CYCLES_LSB +: 2] = last_cycles;
      end
      REG_PC: begin
        next_prdata[PC_W-1:0] = program_counter;
      end
      REG_INSTR: begin
        next_prdata[WORD_W-1:0] = sw_word;
      end
      REG_FLAGS: begin
        next_prdata[7:0] = flag_seen;
      end
      REG_TAKEN_COUNT: begin
        next_prdata[15:0] = taken_count;
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  // Every access completes with no wait: ready rises for the access phase only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~addr_known(paddr);
      if (apb_setup) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule : fcbu_branch_unit

`default_nettype wire

//--- fcbu_pkg.sv
// Shared constants, types and helper functions for the flag-tested branch unit.
package fcbu_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int PC_W = 16;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam int OFS_W = 7;

  // ==========================================================================
  // APB register offsets (byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PC = 8'h08;
  localparam logic [ADDR_W-1:0] REG_INSTR = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_TAKEN_COUNT = 8'h14;

  // ==========================================================================
  // Register fields and reset values
  // ==========================================================================
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_PENDING_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;
  localparam int STAT_CYCLES_LSB = 4;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] INSTR_RESET = 16'h0000;

  // ==========================================================================
  // Instruction word layout of the branch family
  // ==========================================================================
  localparam int FAMILY_LSB = 11;
  localparam logic [4:0] FAMILY_CODE = 5'h1e;
  localparam int POLARITY_BIT = 10;
  localparam int OFS_LSB = 3;
  localparam int SEL_LSB = 0;

  // Status register flag positions as seen on the core flag bus.
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ==========================================================================
  // Timing counts
  // ==========================================================================
  localparam logic [1:0] CYCLES_NOT_TAKEN = 2'h1;
  localparam logic [1:0] CYCLES_TAKEN = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic {FCBU_IDLE, FCBU_BRANCH} fcbu_state_t;

  typedef struct packed {
    logic is_branch;
    logic cond_true;
    logic [PC_W-1:0] offset;
  } fcbu_decode_t;

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Sign-extends the word displacement to the counter width.
  function automatic logic [PC_W-1:0] sext_offset(input logic [OFS_W-1:0] k);
    sext_offset = {{(PC_W-OFS_W){k[OFS_W-1]}}, k};
  endfunction : sext_offset

  // Next counter value: current plus displacement plus one.
  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc,
                                              input logic [PC_W-1:0] ofs);
    pc_step = pc + ofs + 16'h0001;
  endfunction : pc_step

endpackage : fcbu_pkg

//--- fcbu_cond_eval.sv
// Decoder that recognises a flag-tested branch word and evaluates its condition.
`timescale 1ns/10ps
`default_nettype none

module fcbu_cond_eval
  import fcbu_pkg::*;
(
  input wire logic [WORD_W-1:0] word,
  input wire logic [7:0] flags,
  output var fcbu_decode_t dec
);

  logic family;
  logic clear_pol;
  logic supported;
  logic flag_val;
  logic [2:0] sel;

  // Selects the tested flag; other flag selections belong to other units.
  always_comb begin
    family = (word[FAMILY_LSB +: 5] == FAMILY_CODE);
    clear_pol = word[POLARITY_BIT];
    sel = word[SEL_LSB +: 3];
    supported = 1'b0;
    flag_val = 1'b0;
    case (sel)
      FLAG_H: begin
        supported = 1'b1;
        flag_val = flags[FLAG_H]; // see RULE_02 see RULE_03
      end
      FLAG_T: begin
        supported = 1'b1;
        flag_val = flags[FLAG_T]; // see RULE_04 see RULE_05
      end
      FLAG_V: begin
        supported = 1'b1;
        flag_val = flags[FLAG_V]; // see RULE_06 see RULE_07
      end
      FLAG_I: begin
        supported = 1'b1;
        flag_val = flags[FLAG_I]; // see RULE_08 see RULE_09
      end
      FLAG_S: begin
        supported = ~clear_pol;
        flag_val = flags[FLAG_N] ^ flags[FLAG_V]; // see RULE_12
      end
      default: begin
        supported = 1'b0;
        flag_val = 1'b0;
      end
    endcase
    dec.is_branch = family & supported;
    dec.cond_true = family & supported & (clear_pol ? ~flag_val : flag_val);
    dec.offset = sext_offset(word[OFS_LSB +: OFS_W]); // see RULE_14
  end

endmodule : fcbu_cond_eval

`default_nettype wire

//--- fcbu_asserts.sv
// Checker of the branch unit port behaviour, bound to the top module.
`timescale 1ns/10ps
`default_nettype none

module fcbu_asserts
  import fcbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic issue_valid,
  input wire logic [WORD_W-1:0] issue_word,
  input wire logic [7:0] status_flags,
  input wire logic [PC_W-1:0] program_counter,
  input wire logic pc_load,
  input wire logic flush_fetch,
  input wire logic branch_done,
  input wire logic branch_taken
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Evaluates a branch word against the flag byte; select 4 tests negative xor overflow.
  function automatic logic cond_ok(input logic [15:0] w, input logic [7:0] f);
    logic c;
    case (w[2:0])
      3'h4: c = f[2] ^ f[3];
      default: c = f[w[2:0]];
    endcase
    cond_ok = c ^ w[10];
  endfunction : cond_ok

  // ==========================================================================
  // Properties
  // ==========================================================================
  // A software word never shows on the core port, so word checks follow core issues only.
  property p_flush_done;
    flush_fetch |=> branch_done && branch_taken && pc_load;
  endproperty
  a_flush_done: assert property (p_flush_done) else $error("taken branch did not finish");
  property p_taken_pc;
    flush_fetch && $past(issue_valid) |=> program_counter == $past(program_counter) +
      {{9{$past(issue_word[9], 2)}}, $past(issue_word[9:3], 2)} + 16'h0001;
  endproperty
  a_taken_pc: assert property (p_taken_pc) else $error("taken target wrong");
  property p_cond_taken;
    flush_fetch && $past(issue_valid) |-> cond_ok($past(issue_word), $past(status_flags));
  endproperty
  a_cond_taken: assert property (p_cond_taken) else $error("branch taken on false condition");
  property p_cond_false;
    branch_done && !branch_taken && $past(issue_valid) |->
      !cond_ok($past(issue_word), $past(status_flags));
  endproperty
  a_cond_false: assert property (p_cond_false) else $error("true condition not taken");
  property p_step;
    branch_done && !branch_taken |-> program_counter == $past(program_counter) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("sequential step wrong");
  property p_taken_with_done;
    branch_taken |-> branch_done && $past(flush_fetch);
  endproperty
  a_taken_with_done: assert property (p_taken_with_done) else $error("taken pulse alone");
  property p_pc_source;
    $changed(program_counter) |-> pc_load || $past(psel && penable && pwrite && paddr == REG_PC);
  endproperty
  a_pc_source: assert property (p_pc_source) else $error("counter changed unasked");
  property p_apb_ready;
    psel && !penable |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule : fcbu_asserts

bind fcbu_branch_unit fcbu_asserts u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .issue_valid(issue_valid),
  .issue_word(issue_word), .status_flags(status_flags), .program_counter(program_counter),
  .pc_load(pc_load), .flush_fetch(flush_fetch), .branch_done(branch_done),
  .branch_taken(branch_taken));

`default_nettype wire

//--- fcbu_core_model.sv
// Behavioural core model driving the issue strobe, instruction word and status flags.
`timescale 1ns/10ps
`default_nettype none

module fcbu_core_model
  import fcbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [WORD_W-1:0] req_word,
  input wire logic [7:0] req_flags,
  output logic issue_valid,
  output logic [WORD_W-1:0] issue_word,
  output logic [7:0] status_flags
);
  // Issues one word per request, then shows its inverse so a stale word never lingers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      issue_valid <= 1'b0;
      issue_word <= 16'h0000;
    end else begin
      issue_valid <= req;
      issue_word <= req ? req_word : ~issue_word;
    end
  end

  // Status flags load only on request; a branch never writes them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags <= 8'h00;
    end else if (req) begin
      status_flags <= req_flags;
    end
  end
endmodule : fcbu_core_model

`default_nettype wire

//--- flag_conditional_branch_unit_bench.sv
// Self-checking bench of the flag-tested branch unit.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end

module flag_conditional_branch_unit_bench
  import fcbu_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req = 0;
  logic pready, pslverr, err, issue_valid, pc_load, flush_fetch, branch_done, branch_taken;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [WORD_W-1:0] issue_word, req_word = '0;
  logic [7:0] status_flags, req_flags = '0;
  logic [PC_W-1:0] program_counter, exp_pc;
  int err_total = 0, n_checks = 0, cyc = 0;
  // Rows: taken, clear polarity, offset, flag select, flags.
  localparam logic [19:0] ROWS [20] = '{
    {1'b1, 1'b0, 7'h40, 3'h5, 8'h20}, {1'b0, 1'b0, 7'h3f, 3'h5, 8'h00},
    {1'b1, 1'b1, 7'h3f, 3'h5, 8'h00}, {1'b0, 1'b1, 7'h01, 3'h5, 8'h20},
    {1'b1, 1'b0, 7'h7f, 3'h6, 8'h40}, {1'b0, 1'b0, 7'h01, 3'h6, 8'hbf},
    {1'b1, 1'b1, 7'h01, 3'h6, 8'hbf}, {1'b0, 1'b1, 7'h40, 3'h6, 8'h40},
    {1'b1, 1'b0, 7'h05, 3'h3, 8'h08}, {1'b0, 1'b0, 7'h05, 3'h3, 8'hf7},
    {1'b1, 1'b1, 7'h7f, 3'h3, 8'hf7}, {1'b0, 1'b1, 7'h7f, 3'h3, 8'h08},
    {1'b1, 1'b0, 7'h40, 3'h7, 8'h80}, {1'b0, 1'b0, 7'h40, 3'h7, 8'h7f},
    {1'b1, 1'b1, 7'h3f, 3'h7, 8'h7f}, {1'b0, 1'b1, 7'h3f, 3'h7, 8'h80},
    {1'b1, 1'b0, 7'h02, 3'h4, 8'h04}, {1'b1, 1'b0, 7'h02, 3'h4, 8'h08},
    {1'b0, 1'b0, 7'h02, 3'h4, 8'h0c}, {1'b0, 1'b0, 7'h02, 3'h4, 8'h10}};

  fcbu_branch_unit u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .issue_valid(issue_valid), .issue_word(issue_word),
    .status_flags(status_flags), .program_counter(program_counter), .pc_load(pc_load),
    .flush_fetch(flush_fetch), .branch_done(branch_done), .branch_taken(branch_taken));
  fcbu_core_model u_core (.pclk(pclk), .presetn(presetn), .req(req), .req_word(req_word),
    .req_flags(req_flags), .issue_valid(issue_valid), .issue_word(issue_word),
    .status_flags(status_flags));

  // Clock of 50 ns period and a ceiling on the run length.
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // One APB transfer; read data and error are taken at the ready edge.
  // The wait has no limit of its own; a hung slave is caught by the run ceiling.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Issues one branch row and checks outcome, latency and counter.
  task automatic run(input logic [19:0] r);
    int n = 0;
    @(posedge pclk);
    req <= 1'b1; req_word <= {5'h1e, r[18], r[17:11], r[10:8]}; req_flags <= r[7:0];
    @(posedge pclk);
    req <= 1'b0;
    do begin @(posedge pclk); n++; end while (branch_done !== 1'b1 && n < 8);
    exp_pc = r[19] ? exp_pc + {{9{r[17]}}, r[17:11]} + 16'h0001 : exp_pc + 16'h0001;
    `CHK(branch_taken, r[19])
    `CHK(n - 1, r[19] ? 2 : 1)
    `CHK(program_counter, exp_pc)
  endtask : run

  // Reset, the row loop, then register and reset cases.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    exp_pc = PC_RESET;
    `CHK(program_counter, PC_RESET)
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK(rd[CTRL_ENABLE_BIT], CTRL_ENABLE_RESET)
    foreach (ROWS[i]) run(ROWS[i]);
    apb(1'b1, REG_PC, 32'h0000_1234);
    apb(1'b0, REG_PC, 32'h0);
    `CHK(rd[15:0], 16'h1234)
    `CHK(err, 1'b0)
    exp_pc = 16'h1234;
    run(ROWS[0]);
    apb(1'b0, REG_TAKEN_COUNT, 32'h0);
    `CHK(rd[15:0], 16'h000b)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(program_counter, PC_RESET)
    `CHK(branch_done, 1'b0)
    presetn <= 1'b1;
    exp_pc = PC_RESET;
    run(ROWS[17]);
    // A software word waits while disabled, a second one is refused, enable releases the first.
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_INSTR, {16'h0000, FAMILY_CODE, 1'b1, 7'h02, FLAG_I});
    apb(1'b1, REG_INSTR, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[5:0], {CYCLES_TAKEN, 4'hb})
    `CHK(program_counter, 16'h0006)
    apb(1'b0, REG_FLAGS, 32'h0);
    `CHK(rd[7:0], ROWS[17][7:0])
    give_verdict();
  end
endmodule : flag_conditional_branch_unit_bench

`default_nettype wire
